// >>> rtl/rcc_defs.svh
// register offsets, field positions, reset values and strap constants
// assumes inclusion by bare name from the design files only
`ifndef RCC_DEFS_SVH
`define RCC_DEFS_SVH

`define RCC_REG_CTRL_SRC 8'h05
`define RCC_REG_ROUTE 8'h06
`define RCC_REG_CH_EQ 8'h10
`define RCC_REG_CH_GAIN 8'h11
`define RCC_REG_CH_SD 8'h12
`define RCC_REG_CH_STAT 8'h13
`define RCC_REG_QUAD_SEL 8'hFF

`define RCC_CTRL_SRC_BIT 1
`define RCC_QUAD_SEL_LSB 4
`define RCC_QUAD_SEL_MSB 5
`define RCC_QUAD_ONE 2'h1
`define RCC_QUAD_ZERO 2'h0

`define RCC_QUAD_SEL_RST 8'h00
`define RCC_CTRL_SRC_RST 1'h0
`define RCC_ROUTE_RST 4'h0
`define RCC_CH_EQ_RST 7'h00
`define RCC_CH_GAIN_RST 6'h00
`define RCC_CH_SD_RST 2'h0

`define RCC_SLAVE_BASE 7'h18
`define RCC_SLAVE_TOP 7'h27

`endif

// >>> rtl/rcc_pkg.sv
// types shared by the configuration block and its cross-point cells
// assumes nothing of its surroundings
package rcc_pkg;

   typedef enum logic [1:0] {
      ROUTE_STRAIGHT,
      ROUTE_MUX,
      ROUTE_FANOUT,
      ROUTE_CROSS
   } rcc_route_e;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_REG,
      ST_REG_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK
   } rcc_state_e;

endpackage

// >>> rtl/rcc_top.sv
// repeater configuration: smbus slave, shared and channel registers,
// cross-point routing, signal-detect gating and strap address latch
// assumes scl, sda and pins are already synchronous to mclk
`timescale 1ns/1ps
`include "rcc_defs.svh"

// What this block does
// - four 2x2 cross-points on adjacent channel pairs
// - routes: straight, mux, fanout, crossover
// - shared 0x05 bit1 picks pin or register control
// - pin control needs the bit in both quads
// - 0xFF bits 5:4 pick the shared quad
// - first pin drives pairs 0-1, 4-5; second others
// - signal detect enables path, no signal powers off
// - auto detect after reset, registers can override
// - coarse and fine 3-bit boost per channel
// - per-channel coarse stage bypass
// - 2-bit bandwidth field per channel
// - high or low wideband gain per channel
// - 3-bit driver gain field per channel
// - straps sampled once after reset, then latched
// - each strap four levels, sixteen addresses
// - address is 0x18 plus 4*upper plus lower
module rcc_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic [1:0] id_strap_upper,
   input wire logic [1:0] id_strap_lower,
   input wire logic route_select_first,
   input wire logic route_select_second,
   input wire logic [7:0] sig_det,
   input wire logic [7:0] ch_in,
   output logic [7:0] ch_out,
   output logic [7:0] path_en,
   output logic [23:0] eq_coarse_boost,
   output logic [23:0] eq_fine_boost,
   output logic [7:0] eq_coarse_bypass,
   output logic [15:0] eq_bandwidth,
   output logic [7:0] eq_high_gain,
   output logic [23:0] drv_gain,
   output logic [6:0] slave_addr,
   output logic addr_latched
);

   ////////////////////////////////////////////////////////////////////////////
   // strap latch

   logic [6:0] slave_addr_reg;
   logic latched_reg;

   // captured by a clock edge after release, never by the reset itself
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         slave_addr_reg <= `RCC_SLAVE_BASE;
         latched_reg <= 1'b0;
      end else if (!latched_reg) begin
         slave_addr_reg <= `RCC_SLAVE_BASE + {3'h0, id_strap_upper, id_strap_lower};
         latched_reg <= 1'b1;
      end
   end

   assign slave_addr = slave_addr_reg;
   assign addr_latched = latched_reg;

   ////////////////////////////////////////////////////////////////////////////
   // smbus line sampling

   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda_in;
      end
   end

   assign scl_rise = scl & ~scl_q;
   assign scl_fall = ~scl & scl_q;
   assign bus_start = scl & scl_q & sda_q & ~sda_in;
   assign bus_stop = scl & scl_q & ~sda_q & sda_in;

   ////////////////////////////////////////////////////////////////////////////
   // smbus slave state machine

   rcc_pkg::rcc_state_e state_reg;
   logic [7:0] shift_reg;
   logic [7:0] ptr_reg;
   logic [2:0] cnt_reg;
   logic byte_full_reg;
   logic rw_reg;
   logic drive_reg;
   logic [7:0] rd_data;
   logic wr_en;

   assign wr_en = (state_reg == rcc_pkg::ST_WDATA) && scl_fall && byte_full_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= rcc_pkg::ST_IDLE;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         cnt_reg <= 3'h0;
         byte_full_reg <= 1'b0;
         rw_reg <= 1'b0;
         drive_reg <= 1'b0;
      end else if (bus_start) begin
         state_reg <= rcc_pkg::ST_ADDR;
         cnt_reg <= 3'h0;
         byte_full_reg <= 1'b0;
         drive_reg <= 1'b0;
      end else if (bus_stop) begin
         state_reg <= rcc_pkg::ST_IDLE;
         drive_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            rcc_pkg::ST_IDLE: begin
            end
            rcc_pkg::ST_ADDR, rcc_pkg::ST_REG, rcc_pkg::ST_WDATA: begin
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], sda_in};
                  cnt_reg <= cnt_reg + 3'h1;
                  byte_full_reg <= (cnt_reg == 3'h7);
               end else if (scl_fall && byte_full_reg) begin
                  byte_full_reg <= 1'b0;
                  if (state_reg == rcc_pkg::ST_ADDR) begin
                     if (latched_reg && shift_reg[7:1] == slave_addr_reg) begin
                        rw_reg <= shift_reg[0];
                        drive_reg <= 1'b1;
                        state_reg <= rcc_pkg::ST_ADDR_ACK;
                     end else begin
                        state_reg <= rcc_pkg::ST_IDLE;
                     end
                  end else if (state_reg == rcc_pkg::ST_REG) begin
                     ptr_reg <= shift_reg;
                     drive_reg <= 1'b1;
                     state_reg <= rcc_pkg::ST_REG_ACK;
                  end else begin
                     ptr_reg <= ptr_reg + 8'h01;
                     drive_reg <= 1'b1;
                     state_reg <= rcc_pkg::ST_WDATA_ACK;
                  end
               end
            end
            rcc_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_reg <= 3'h0;
                  if (rw_reg) begin
                     shift_reg <= {rd_data[6:0], 1'b0};
                     drive_reg <= ~rd_data[7];
                     ptr_reg <= ptr_reg + 8'h01;
                     state_reg <= rcc_pkg::ST_RDATA;
                  end else begin
                     drive_reg <= 1'b0;
                     state_reg <= rcc_pkg::ST_REG;
                  end
               end
            end
            rcc_pkg::ST_REG_ACK, rcc_pkg::ST_WDATA_ACK: begin
               if (scl_fall) begin
                  cnt_reg <= 3'h0;
                  drive_reg <= 1'b0;
                  state_reg <= rcc_pkg::ST_WDATA;
               end
            end
            rcc_pkg::ST_RDATA: begin
               if (scl_fall) begin
                  if (cnt_reg == 3'h7) begin
                     drive_reg <= 1'b0;
                     state_reg <= rcc_pkg::ST_RDATA_ACK;
                  end else begin
                     drive_reg <= ~shift_reg[7];
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     cnt_reg <= cnt_reg + 3'h1;
                  end
               end
            end
            rcc_pkg::ST_RDATA_ACK: begin
               if (scl_rise) begin
                  byte_full_reg <= ~sda_in;
               end else if (scl_fall) begin
                  byte_full_reg <= 1'b0;
                  cnt_reg <= 3'h0;
                  if (byte_full_reg) begin
                     shift_reg <= {rd_data[6:0], 1'b0};
                     drive_reg <= ~rd_data[7];
                     ptr_reg <= ptr_reg + 8'h01;
                     state_reg <= rcc_pkg::ST_RDATA;
                  end else begin
                     state_reg <= rcc_pkg::ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe_n = ~drive_reg;

   ////////////////////////////////////////////////////////////////////////////
   // register file

   logic [7:0] quad_sel_reg;
   logic [1:0] ctrl_src_reg;
   logic [3:0] route_reg [2];
   logic [6:0] ch_eq_reg [8];
   logic [5:0] ch_gain_reg [8];
   logic [1:0] ch_sd_reg [8];
   logic [1:0] quad_code;
   logic quad_valid;
   logic quad_idx;
   logic [2:0] ch_idx;

   assign quad_code = quad_sel_reg[`RCC_QUAD_SEL_MSB:`RCC_QUAD_SEL_LSB];
   assign quad_valid = (quad_code == `RCC_QUAD_ZERO) || (quad_code == `RCC_QUAD_ONE);
   assign quad_idx = (quad_code == `RCC_QUAD_ONE);
   assign ch_idx = {quad_idx, quad_sel_reg[1:0]};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         quad_sel_reg <= `RCC_QUAD_SEL_RST;
      end else if (wr_en && ptr_reg == `RCC_REG_QUAD_SEL) begin
         quad_sel_reg <= shift_reg;
      end
   end

   // quad select must be written first; an unmapped quad swallows the write
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_src_reg <= {2{`RCC_CTRL_SRC_RST}};
         route_reg[0] <= `RCC_ROUTE_RST;
         route_reg[1] <= `RCC_ROUTE_RST;
      end else if (wr_en && quad_valid) begin
         if (ptr_reg == `RCC_REG_CTRL_SRC) begin
            ctrl_src_reg[quad_idx] <= shift_reg[`RCC_CTRL_SRC_BIT];
         end
         if (ptr_reg == `RCC_REG_ROUTE) begin
            route_reg[quad_idx] <= shift_reg[3:0];
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 8; i++) begin
            ch_eq_reg[i] <= `RCC_CH_EQ_RST;
            ch_gain_reg[i] <= `RCC_CH_GAIN_RST;
            ch_sd_reg[i] <= `RCC_CH_SD_RST;
         end
      end else if (wr_en && quad_valid) begin
         if (ptr_reg == `RCC_REG_CH_EQ) begin
            ch_eq_reg[ch_idx] <= shift_reg[6:0];
         end
         if (ptr_reg == `RCC_REG_CH_GAIN) begin
            ch_gain_reg[ch_idx] <= shift_reg[5:0];
         end
         if (ptr_reg == `RCC_REG_CH_SD) begin
            ch_sd_reg[ch_idx] <= shift_reg[1:0];
         end
      end
   end

   always_comb begin
      rd_data = 8'h00;
      if (ptr_reg == `RCC_REG_QUAD_SEL) begin
         rd_data = quad_sel_reg;
      end else if (quad_valid) begin
         case (ptr_reg)
            `RCC_REG_CTRL_SRC: rd_data = {6'h00, ctrl_src_reg[quad_idx], 1'b0};
            `RCC_REG_ROUTE: rd_data = {4'h0, route_reg[quad_idx]};
            `RCC_REG_CH_EQ: rd_data = {1'b0, ch_eq_reg[ch_idx]};
            `RCC_REG_CH_GAIN: rd_data = {2'h0, ch_gain_reg[ch_idx]};
            `RCC_REG_CH_SD: rd_data = {6'h00, ch_sd_reg[ch_idx]};
            `RCC_REG_CH_STAT: rd_data = {6'h00, path_en[ch_idx], sig_det[ch_idx]};
            default: rd_data = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // analog control fields and signal-detect gating

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         eq_coarse_boost[i*3 +: 3] = ch_eq_reg[i][2:0];
         eq_fine_boost[i*3 +: 3] = ch_eq_reg[i][5:3];
         eq_coarse_bypass[i] = ch_eq_reg[i][6];
         eq_bandwidth[i*2 +: 2] = ch_gain_reg[i][1:0];
         eq_high_gain[i] = ch_gain_reg[i][2];
         drv_gain[i*3 +: 3] = ch_gain_reg[i][5:3];
      end
   end

   logic [7:0] path_en_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         path_en_reg <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            path_en_reg[i] <= ch_sd_reg[i][0] ? ch_sd_reg[i][1] : sig_det[i];
         end
      end
   end

   assign path_en = path_en_reg;

   ////////////////////////////////////////////////////////////////////////////
   // cross-points

   logic pin_mode;
   logic [7:0] gated_in;
   rcc_pkg::rcc_route_e pair_mode [4];

   assign pin_mode = ctrl_src_reg[0] & ctrl_src_reg[1];
   assign gated_in = ch_in & path_en_reg;

   always_comb begin
      for (int p = 0; p < 4; p++) begin
         if (pin_mode) begin
            // pin low keeps the pair straight, pin high crosses it
            if ((p % 2 == 0) ? route_select_first : route_select_second) begin
               pair_mode[p] = rcc_pkg::ROUTE_CROSS;
            end else begin
               pair_mode[p] = rcc_pkg::ROUTE_STRAIGHT;
            end
         end else begin
            pair_mode[p] = rcc_pkg::rcc_route_e'(route_reg[p / 2][(p % 2) * 2 +: 2]);
         end
      end
   end

   for (genvar g = 0; g < 4; g++) begin : g_pair
      rcc_xpoint u_xpoint (
         .mclk(mclk),
         .rst_n(rst_n),
         .mode(pair_mode[g]),
         .in_a(gated_in[2 * g]),
         .in_b(gated_in[2 * g + 1]),
         .out_a(ch_out[2 * g]),
         .out_b(ch_out[2 * g + 1])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_pin_mode;
      pin_mode && !route_select_first |-> pair_mode[0] == rcc_pkg::ROUTE_STRAIGHT
         && pair_mode[2] == pair_mode[0];
   endproperty
   a_pin_mode: assert property (p_pin_mode) else $error("pin routing wrong");

   property p_both_quads;
      !(ctrl_src_reg[0] && ctrl_src_reg[1]) |-> pair_mode[1] == route_reg[0][3:2];
   endproperty
   a_both_quads: assert property (p_both_quads) else $error("pin mode without both quads");

   property p_src_write;
      wr_en && ptr_reg == `RCC_REG_CTRL_SRC && quad_code == `RCC_QUAD_ONE
         |=> ctrl_src_reg[1] == $past(shift_reg[1]) && $stable(ctrl_src_reg[0]);
   endproperty
   a_src_write: assert property (p_src_write) else $error("quad select ignored");

   property p_auto_detect;
      !ch_sd_reg[0][0] |=> path_en[0] == $past(sig_det[0]);
   endproperty
   a_auto_detect: assert property (p_auto_detect) else $error("detect gating wrong");

   property p_eq_write;
      wr_en && ptr_reg == `RCC_REG_CH_EQ && quad_code == `RCC_QUAD_ZERO
         && quad_sel_reg[1:0] == 2'h0 |=> eq_coarse_boost[2:0] == $past(shift_reg[2:0])
         && eq_coarse_bypass[0] == $past(shift_reg[6]);
   endproperty
   a_eq_write: assert property (p_eq_write) else $error("eq field not stored");

   property p_latch_once;
      latched_reg |=> latched_reg && $stable(slave_addr_reg);
   endproperty
   a_latch_once: assert property (p_latch_once) else $error("address relatched");

   property p_addr_map;
      $rose(latched_reg) |-> slave_addr_reg
         == `RCC_SLAVE_BASE + {3'h0, $past(id_strap_upper), $past(id_strap_lower)}
         && slave_addr_reg <= `RCC_SLAVE_TOP;
   endproperty
   a_addr_map: assert property (p_addr_map) else $error("slave address wrong");

   sequence s_addr_done;
      state_reg == rcc_pkg::ST_ADDR && scl_fall && byte_full_reg && !bus_start && !bus_stop;
   endsequence

   property p_addr_reject;
      s_addr_done ##0 shift_reg[7:1] != slave_addr_reg
         |=> state_reg == rcc_pkg::ST_IDLE && !drive_reg;
   endproperty
   a_addr_reject: assert property (p_addr_reject) else $error("foreign address acked");

   property p_addr_accept;
      s_addr_done ##0 shift_reg[7:1] == slave_addr_reg
         |=> drive_reg && state_reg == rcc_pkg::ST_ADDR_ACK;
   endproperty
   a_addr_accept: assert property (p_addr_accept) else $error("own address not acked");

endmodule // rcc_top

// >>> rtl/rcc_xpoint.sv
// one 2x2 cross-point between an adjacent channel pair, registered outputs
// assumes mode and inputs synchronous to mclk
`timescale 1ns/1ps

module rcc_xpoint (
   input wire logic mclk,
   input wire logic rst_n,
   input wire rcc_pkg::rcc_route_e mode,
   input wire logic in_a,
   input wire logic in_b,
   output logic out_a,
   output logic out_b
);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_a <= 1'b0;
         out_b <= 1'b0;
      end else begin
         unique case (mode)
            rcc_pkg::ROUTE_STRAIGHT: begin
               out_a <= in_a;
               out_b <= in_b;
            end
            rcc_pkg::ROUTE_MUX: begin
               // unused output held quiet rather than left toggling
               out_a <= in_b;
               out_b <= 1'b0;
            end
            rcc_pkg::ROUTE_FANOUT: begin
               out_a <= in_a;
               out_b <= in_a;
            end
            rcc_pkg::ROUTE_CROSS: begin
               out_a <= in_b;
               out_b <= in_a;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   property p_cross;
      @(posedge mclk) disable iff (!rst_n)
      mode == rcc_pkg::ROUTE_CROSS |=> out_a == $past(in_b) && out_b == $past(in_a);
   endproperty
   a_cross: assert property (p_cross) else $error("cross routing wrong");

   property p_fanout;
      @(posedge mclk) disable iff (!rst_n)
      mode == rcc_pkg::ROUTE_FANOUT |=> out_a == out_b && out_a == $past(in_a);
   endproperty
   a_fanout: assert property (p_fanout) else $error("fanout routing wrong");

endmodule // rcc_xpoint

// >>> test/rcc_host.sv
// smbus host model for the repeater configuration block
// assumes the bench resolves sda from all drivers with a pull-up
`timescale 1ns/1ps

module rcc_host (
   input wire logic mclk,
   input wire logic sda_wire,
   output logic scl,
   output logic sda_drv,
   output logic rd_valid,
   output logic [7:0] rd_data
);
   // scl idles high and stands still between frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      rd_valid = 1'b0;
      rd_data = 8'h00;
   end

   ////////////////////////////////////////////////////////////////
   // sda moves only while scl is low, so no false start or stop
   task automatic pulse(input logic b, output logic s);
      repeat (2) @(negedge mclk);
      sda_drv = b;
      repeat (2) @(negedge mclk);
      scl = 1'b1;
      repeat (2) @(negedge mclk);
      s = sda_wire;
      repeat (2) @(negedge mclk);
      scl = 1'b0;
   endtask

   // start or repeated start when first is 1, stop when 0
   task automatic cond(input logic first);
      repeat (2) @(negedge mclk);
      sda_drv = first;
      repeat (2) @(negedge mclk);
      scl = 1'b1;
      repeat (4) @(negedge mclk);
      sda_drv = !first;
      repeat (4) @(negedge mclk);
      if (first) scl = 1'b0;
   endtask

   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) pulse(b[i], s);
      pulse(1'b1, s);
      ack = !s;
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic write(input logic [6:0] dev, input logic [7:0] ptr,
                        input logic [7:0] data, output logic ack);
      logic a0, a1, a2;
      cond(1'b1);
      send({dev, 1'b0}, a0);
      send(ptr, a1);
      send(data, a2);
      cond(1'b0);
      ack = a0 & a1 & a2;
   endtask

   // single byte read, ended by a nack then stop
   task automatic read(input logic [6:0] dev, input logic [7:0] ptr, output logic ack);
      logic a0, a1, a2, s;
      logic [7:0] d;
      cond(1'b1);
      send({dev, 1'b0}, a0);
      send(ptr, a1);
      cond(1'b1);
      send({dev, 1'b1}, a2);
      for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
      pulse(1'b1, s);
      cond(1'b0);
      ack = a0 & a1 & a2;
      rd_data = d;
      rd_valid = 1'b1;
      @(negedge mclk);
      rd_valid = 1'b0;
   endtask
endmodule // rcc_host

// >>> test/tb_rcc_top.sv
// self-checking bench for the repeater configuration block
// assumes the host model in rcc_host and a pull-up on sda
`timescale 1ns/1ps

module tb_rcc_top;
   logic mclk, rst_n, scl, sda_drv, sda_wire, sda_out, sda_oe_n, rd_valid, addr_latched, ack;
   logic route_select_first, route_select_second;
   logic [1:0] id_strap_upper, id_strap_lower;
   logic [7:0] sig_det, ch_in, ch_out, path_en, eq_coarse_bypass, eq_high_gain, rd_data;
   logic [23:0] eq_coarse_boost, eq_fine_boost, drv_gain, xc, xf, xd;
   logic [15:0] eq_bandwidth, xb;
   logic [7:0] m, e, g, xp, xh;
   logic [6:0] slave_addr, dev;
   int fails, n_tests;
   logic [7:0] exp_q[$];

   // open drain: anyone pulling low wins over the pull-up
   assign sda_wire = sda_drv & (sda_oe_n | sda_out);

   rcc_top rcc_top_i (.mclk, .rst_n, .scl, .sda_in(sda_wire), .sda_out, .sda_oe_n,
      .id_strap_upper, .id_strap_lower, .route_select_first, .route_select_second,
      .sig_det, .ch_in, .ch_out, .path_en, .eq_coarse_boost, .eq_fine_boost,
      .eq_coarse_bypass, .eq_bandwidth, .eq_high_gain, .drv_gain, .slave_addr,
      .addr_latched);
   rcc_host rcc_host_i (.mclk, .sda_wire, .scl, .sda_drv, .rd_valid, .rd_data);

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // read data is judged here against the oldest note
   always @(posedge mclk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) chk("unexpected read", 24'h0, 24'h1);
         else chk("read data", 24'(exp_q.pop_front()), 24'(rd_data));
      end
   end

   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      rcc_host_i.write(dev, ptr, d, ack);
      chk("write ack", 24'h1, 24'(ack));
   endtask

   task automatic rd(input logic [7:0] ptr, input logic [7:0] x);
      exp_q.push_back(x);
      rcc_host_i.read(dev, ptr, ack);
      chk("read ack", 24'h1, 24'(ack));
   endtask

   task automatic do_reset();
      @(negedge mclk);
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      repeat (2) @(negedge mclk);
   endtask

   // per pair: a is the even channel, b the odd one; inputs gated by detect
   function automatic logic [7:0] route(input logic [7:0] md, input logic [7:0] x);
      logic [7:0] y;
      for (int p = 0; p < 4; p++) begin
         case (md[2*p+:2])
            2'h0: y[2*p+:2] = x[2*p+:2];
            2'h1: y[2*p+:2] = {1'b0, x[2*p+1]};
            2'h2: y[2*p+:2] = {2{x[2*p]}};
            default: y[2*p+:2] = {x[2*p], x[2*p+1]};
         endcase
      end
      return y;
   endfunction

   task automatic route_chk(input logic [7:0] md);
      repeat (4) begin
         ch_in = 8'($urandom);
         repeat (3) @(negedge mclk);
         chk("ch_out", 24'(route(md, ch_in & sig_det)), 24'(ch_out));
      end
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      #(8 * 60000);
      fails++;
      test_done();
   end

   initial begin
      rst_n = 1'b0;
      {route_select_first, route_select_second} = 2'h0;
      {id_strap_upper, id_strap_lower} = 4'h0;
      sig_det = 8'hFF;
      ch_in = 8'h00;
      fails = 0;
      n_tests = 0;
      dev = 7'h18;
      void'($urandom(32'hA8B25260));
      for (int s = 0; s < 16; s++) begin
         {id_strap_upper, id_strap_lower} = 4'(s);
         do_reset();
         chk("slave_addr", 24'(7'h18 + s), 24'(slave_addr));
         chk("addr_latched", 24'h1, 24'(addr_latched));
      end
      {id_strap_upper, id_strap_lower} = 4'($urandom);
      do_reset();
      dev = 7'h18 + {id_strap_upper, id_strap_lower};
      {id_strap_upper, id_strap_lower} = ~{id_strap_upper, id_strap_lower};
      repeat (3) @(negedge mclk);
      chk("strap held", 24'(dev), 24'(slave_addr));
      rcc_host_i.write(dev ^ 7'h01, 8'h05, 8'h02, ack);
      chk("foreign ack", 24'h0, 24'(ack));
      rd(8'h05, 8'h00);
      sig_det = 8'($urandom);
      repeat (3) @(negedge mclk);
      chk("path_en auto", 24'(sig_det), 24'(path_en));
      sig_det = 8'hFF;
      wr(8'hFF, 8'h12);
      rd(8'hFF, 8'h12);
      wr(8'h12, 8'h01);
      repeat (3) @(negedge mclk);
      chk("path_en off", 24'hBF, 24'(path_en));
      sig_det = 8'h00;
      wr(8'h12, 8'h03);
      repeat (3) @(negedge mclk);
      chk("path_en on", 24'h40, 24'(path_en));
      wr(8'h12, 8'h00);
      // every channel gets its own random fields; whole vectors catch cross-talk
      for (int c = 0; c < 8; c++) begin
         e = 8'($urandom) & 8'h7F;
         g = 8'($urandom) & 8'h3F;
         {xc[3*c+:3], xf[3*c+:3], xp[c]} = {e[2:0], e[5:3], e[6]};
         {xd[3*c+:3], xh[c], xb[2*c+:2]} = g[5:0];
         wr(8'hFF, 8'(((c / 4) << 4) | (c % 4)));
         wr(8'h10, e);
         wr(8'h11, g);
         rd(8'h10, e);
         rd(8'h11, g);
      end
      chk("coarse", xc, eq_coarse_boost);
      chk("fine", xf, eq_fine_boost);
      chk("bypass", 24'(xp), 24'(eq_coarse_bypass));
      chk("bandwidth", 24'(xb), 24'(eq_bandwidth));
      chk("wide gain", 24'(xh), 24'(eq_high_gain));
      chk("drv_gain", xd, drv_gain);
      sig_det = 8'($urandom);
      for (int k = 0; k < 4; k++) begin
         m = {2'(k + 3), 2'(k + 2), 2'(k + 1), 2'(k)};
         wr(8'hFF, 8'h00);
         wr(8'h06, {4'h0, m[3:0]});
         wr(8'hFF, 8'h10);
         wr(8'h06, {4'h0, m[7:4]});
         route_chk(m);
      end
      {route_select_second, route_select_first} = 2'h3;
      wr(8'h05, 8'h02);
      route_chk(m);
      wr(8'hFF, 8'h00);
      wr(8'h05, 8'h02);
      rd(8'h05, 8'h02);
      for (int p = 0; p < 4; p++) begin
         {route_select_second, route_select_first} = 2'(p);
         route_chk({2{{2{route_select_second}}, {2{route_select_first}}}});
      end
      wr(8'h05, 8'h00);
      route_chk(m);
      test_done();
   end
endmodule // tb_rcc_top
